/* File: core/acq_record_sequencer.v */
/*
 Acquisition record sequencer: chooses record slots, counts captures and
 averages, times the recycle interval and exposes settings over classic
 Wishbone. Assumes capture_done_i pulses one cycle from the capture engine
 on the same clock; trig_i and stop_key_i are external pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acq_seq_consts.vh"

module acq_record_sequencer #(
   parameter RECYCLE_256_CYC = (`RECYCLE_256_MS * (`CLK_HZ / 1000)),
   parameter RECYCLE_512_CYC = (`RECYCLE_512_MS * (`CLK_HZ / 1000)),
   parameter RECYCLE_1024_CYC = (`RECYCLE_1024_MS * (`CLK_HZ / 1000)),
   parameter FAST_512_CYC = (`CLK_HZ / `FAST_RATE_HZ),
   parameter REFRESH_CYC = (`REFRESH_S * `CLK_HZ),
   parameter TRIG_TIMEOUT_CYC = (`TRIG_TIMEOUT_MS * (`CLK_HZ / 1000))
) (
   input wire clk_i,              // System clock
   input wire rst_i,              // Synchronous reset, active high
   input wire cyc_i,              // Wishbone cycle
   input wire stb_i,              // Wishbone strobe
   input wire we_i,               // Wishbone write enable
   input wire [7:0] adr_i,        // Wishbone byte address
   input wire [31:0] dat_i,       // Wishbone write data
   input wire [3:0] sel_i,        // Wishbone byte selects
   output reg [31:0] dat_o,       // Wishbone read data
   output reg ack_o,              // Wishbone acknowledge
   input wire trig_i,             // Trigger pin, asynchronous
   input wire stop_key_i,         // Front-panel stop key, asynchronous
   input wire readout_req_i,      // Waveform readout query pending
   input wire capture_done_i,     // Capture finished pulse
   output reg arm_o,              // Capture engine armed
   output reg [3:0] slot_o,       // Slot being filled, 0 means slot 1
   output reg [1:0] rec_len_o,    // Record length of current sequence
   output reg [3:0] win_span_o,   // Capture window span step
   output reg avg_clear_o,        // Clear average accumulator pulse
   output reg avg_accum_o,        // Accumulate this capture pulse
   output reg disp_refresh_o,     // Show partial average pulse
   output reg readout_grant_o,    // Readout query may be answered
   output reg busy_o              // Acquisition running
);
   localparam S_IDLE = 2'h0;
   localparam S_ARM = 2'h1;
   localparam S_RECYCLE = 2'h2;

   reg [1:0] trig_s1_ff, stop_s1_ff;
   reg [1:0] state_ff;
   reg [1:0] mode_cfg_ff, len_cfg_ff, mode_ff;
   reg hold_cfg_ff, fast_cfg_ff, hold_ff, fast_ff;
   reg [3:0] first_cfg_ff, nrec_cfg_ff, nrec_ff, win_cfg_ff, done_cnt_ff;
   reg [10:0] navg_cfg_ff, navg_ff, avg_cnt_ff;
   reg [31:0] timer_ff, refresh_ff, idle_ff;
   reg start_ff, stop_ff, cfg_chg_ff, avg_done_ff;

   wire trig_sync = trig_s1_ff[1];
   wire stop_sync = stop_s1_ff[1];
   wire bus_req = cyc_i & stb_i & ~ack_o;
   wire bus_wr = bus_req & we_i;
   wire wr_ctrl = bus_wr & (adr_i == `OFS_CTRL) & sel_i[0];
   wire wr_cfg = bus_wr & (adr_i == `OFS_CFG);
   wire wr_cnt = bus_wr & (adr_i == `OFS_CNT);
   wire wr_win = bus_wr & (adr_i == `OFS_WIN) & sel_i[0];
   wire any_stop = stop_sync | stop_ff | (wr_ctrl & dat_i[`CTRL_STOP_BIT]);
   wire trig_lost = (idle_ff >= TRIG_TIMEOUT_CYC);
   reg [31:0] recycle_cyc;

   // Recycle time follows the latched length; fast option only shortens 512
   always @* begin
      case (rec_len_o)
         `LEN_256: recycle_cyc = RECYCLE_256_CYC;
         `LEN_1024: recycle_cyc = RECYCLE_1024_CYC;
         default: recycle_cyc = fast_ff ? FAST_512_CYC : RECYCLE_512_CYC;
      endcase
   end

   // Pins pass two flip-flops before use
   always @(posedge clk_i) begin
      if (rst_i) begin
         trig_s1_ff <= 2'h0;
         stop_s1_ff <= 2'h0;
      end else begin
         trig_s1_ff <= {trig_s1_ff[0], trig_i};
         stop_s1_ff <= {stop_s1_ff[0], stop_key_i};
      end
   end

   // Register writes and bus answer
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
         mode_cfg_ff <= `RST_MODE;
         hold_cfg_ff <= 1'b0;
         fast_cfg_ff <= 1'b0;
         len_cfg_ff <= `RST_LEN;
         first_cfg_ff <= `RST_FIRST;
         nrec_cfg_ff <= `RST_NREC;
         navg_cfg_ff <= `RST_NAVG;
         win_cfg_ff <= `RST_WIN;
         start_ff <= 1'b0;
         cfg_chg_ff <= 1'b0;
      end else begin
         ack_o <= bus_req;
         start_ff <= wr_ctrl & dat_i[`CTRL_START_BIT];
         cfg_chg_ff <= wr_cfg | wr_cnt | wr_win;
         if (wr_cfg && sel_i[0]) begin
            mode_cfg_ff <= (dat_i[1:0] == 2'h3) ? `MODE_NORMAL : dat_i[1:0];
            hold_cfg_ff <= dat_i[`CFG_HOLD_BIT];
            fast_cfg_ff <= dat_i[`CFG_FAST_BIT];
            len_cfg_ff <= (dat_i[5:4] == 2'h3) ? `LEN_1024 : dat_i[5:4];
         end
         if (wr_cfg && sel_i[1]) begin
            first_cfg_ff <= dat_i[11:8];
            nrec_cfg_ff <= dat_i[15:12];
         end
         // Average count stored minus one so 1..1024 fits 10 bits cleanly
         if (wr_cnt && sel_i[0] && sel_i[1])
            navg_cfg_ff <= (dat_i[10:0] == 11'h0) ? 11'h0 :
                           ((dat_i[10:0] > 11'h400) ? 11'h3FF : dat_i[10:0] - 11'h001);
         if (wr_win)
            win_cfg_ff <= (dat_i[3:0] > `WIN_MAX_STEP) ? `WIN_MAX_STEP : dat_i[3:0];
         dat_o <= 32'h0;
         if (bus_req && !we_i) begin
            case (adr_i)
               `OFS_CFG: dat_o <= {16'h0, nrec_cfg_ff, first_cfg_ff, 2'h0, len_cfg_ff,
                                   fast_cfg_ff, hold_cfg_ff, mode_cfg_ff};
               `OFS_CNT: dat_o <= {21'h0, navg_cfg_ff};
               `OFS_STATUS: dat_o <= {16'h0, avg_cnt_ff[10:0], slot_o, busy_o};
               `OFS_WIN: dat_o <= {28'h0, win_cfg_ff};
               default: dat_o <= 32'h0;
            endcase
         end
      end
   end

   // Sequencing state machine
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= S_IDLE;
         mode_ff <= `RST_MODE;
         hold_ff <= 1'b0;
         fast_ff <= 1'b0;
         nrec_ff <= 4'h0;
         navg_ff <= 11'h0;
         rec_len_o <= `RST_LEN;
         win_span_o <= `RST_WIN;
         slot_o <= 4'h0;
         done_cnt_ff <= 4'h0;
         avg_cnt_ff <= 11'h0;
         timer_ff <= 32'h0;
         refresh_ff <= 32'h0;
         idle_ff <= 32'h0;
         stop_ff <= 1'b0;
         avg_done_ff <= 1'b0;
         arm_o <= 1'b0;
         busy_o <= 1'b0;
         avg_clear_o <= 1'b0;
         avg_accum_o <= 1'b0;
         disp_refresh_o <= 1'b0;
         readout_grant_o <= 1'b0;
      end else begin
         avg_clear_o <= 1'b0;
         avg_accum_o <= 1'b0;
         disp_refresh_o <= 1'b0;
         stop_ff <= 1'b0;
         readout_grant_o <= readout_req_i & (mode_ff != `MODE_AVERAGE | avg_done_ff);
         case (state_ff)
            S_IDLE: begin
               arm_o <= 1'b0;
               busy_o <= 1'b0;
               if (start_ff) begin
                  mode_ff <= mode_cfg_ff;
                  hold_ff <= hold_cfg_ff;
                  fast_ff <= fast_cfg_ff;
                  nrec_ff <= (mode_cfg_ff == `MODE_ADVANCE) ? nrec_cfg_ff : 4'h0;
                  navg_ff <= (mode_cfg_ff == `MODE_AVERAGE) ? navg_cfg_ff : 11'h0;
                  rec_len_o <= len_cfg_ff;
                  win_span_o <= win_cfg_ff;
                  slot_o <= first_cfg_ff;
                  done_cnt_ff <= 4'h0;
                  avg_cnt_ff <= 11'h0;
                  avg_done_ff <= 1'b0;
                  avg_clear_o <= (mode_cfg_ff == `MODE_AVERAGE);
                  refresh_ff <= 32'h0;
                  idle_ff <= 32'h0;
                  busy_o <= 1'b1;
                  arm_o <= 1'b1;
                  state_ff <= S_ARM;
               end
            end
            S_ARM: begin
               idle_ff <= trig_sync ? 32'h0 : idle_ff + 32'h1;
               if (mode_ff == `MODE_AVERAGE) begin
                  refresh_ff <= (refresh_ff >= REFRESH_CYC - 1) ? 32'h0 : refresh_ff + 32'h1;
                  disp_refresh_o <= (refresh_ff >= REFRESH_CYC - 1);
               end
               if (any_stop || trig_lost) begin
                  arm_o <= 1'b0;
                  state_ff <= S_IDLE;
               end else if (mode_ff == `MODE_AVERAGE && cfg_chg_ff) begin
                  avg_cnt_ff <= 11'h0;
                  avg_clear_o <= 1'b1;
                  avg_done_ff <= 1'b0;
               end else if (capture_done_i) begin
                  arm_o <= 1'b0;
                  timer_ff <= 32'h0;
                  state_ff <= S_RECYCLE;
                  case (mode_ff)
                     `MODE_ADVANCE: begin
                        slot_o <= slot_o + 4'h1; // wraps 16 to 1
                        done_cnt_ff <= done_cnt_ff + 4'h1;
                        if (done_cnt_ff == nrec_ff) begin
                           // Step back to the latched first slot, not the live setting
                           slot_o <= slot_o - nrec_ff;
                           done_cnt_ff <= 4'h0;
                           if (hold_ff)
                              state_ff <= S_IDLE;
                        end
                     end
                     `MODE_AVERAGE: begin
                        avg_accum_o <= 1'b1;
                        avg_cnt_ff <= avg_cnt_ff + 11'h1;
                        if (avg_cnt_ff == navg_ff) begin
                           avg_done_ff <= 1'b1;
                           avg_cnt_ff <= 11'h0;
                           if (hold_ff)
                              state_ff <= S_IDLE;
                        end
                     end
                     default: begin
                        if (hold_ff)
                           state_ff <= S_IDLE;
                     end
                  endcase
               end
            end
            S_RECYCLE: begin
               // A setting change between captures also throws the partial away
               if (mode_ff == `MODE_AVERAGE && cfg_chg_ff) begin
                  avg_cnt_ff <= 11'h0;
                  avg_done_ff <= 1'b0;
                  avg_clear_o <= 1'b1;
               end
               if (any_stop) begin
                  state_ff <= S_IDLE;
               end else if (timer_ff >= recycle_cyc - 1) begin
                  if (mode_ff == `MODE_AVERAGE && avg_done_ff) begin
                     avg_done_ff <= 1'b0;
                     avg_clear_o <= 1'b1;
                  end
                  idle_ff <= 32'h0;
                  arm_o <= 1'b1;
                  state_ff <= S_ARM;
               end else begin
                  timer_ff <= timer_ff + 32'h1;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: pkg/acq_seq_consts.vh */
/*
 Constants for the acquisition record sequencer: register offsets,
 field positions, reset values and timing counts.
 Assumes a 125 MHz system clock.
*/
`ifndef ACQ_SEQ_CONSTS_VH
`define ACQ_SEQ_CONSTS_VH

`define CLK_PERIOD_NS 8
`define CLK_HZ 125000000

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CFG 8'h04
`define OFS_CNT 8'h08
`define OFS_STATUS 8'h0C
`define OFS_WIN 8'h10

// Mode encodings
`define MODE_NORMAL 2'h0
`define MODE_ADVANCE 2'h1
`define MODE_AVERAGE 2'h2

// Record length encodings
`define LEN_256 2'h0
`define LEN_512 2'h1
`define LEN_1024 2'h2

// Field positions in the configuration and count registers
`define CFG_MODE_LSB 0
`define CFG_HOLD_BIT 2
`define CFG_FAST_BIT 3
`define CFG_LEN_LSB 4
`define CFG_FIRST_LSB 8
`define CFG_NREC_LSB 12
`define CNT_NAVG_LSB 0

// Control register bits
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1

// Reset values
`define RST_MODE 2'h0
`define RST_LEN 2'h1
`define RST_FIRST 4'h0
`define RST_NREC 4'h0
`define RST_NAVG 11'h010
`define RST_WIN 4'h7

// Window span steps, 5 ns at step zero
`define WIN_MIN_NS 5
`define WIN_MAX_STEP 4'hD

// Recycle, refresh and trigger timeout times
`define RECYCLE_256_MS 250
`define RECYCLE_512_MS 480
`define RECYCLE_1024_MS 700
`define FAST_RATE_HZ 10
`define REFRESH_S 5
`define TRIG_TIMEOUT_MS 1000

`endif

/* File: verification/acq_seq_monitor.sv */
/* Port checker for acq_record_sequencer.
   Sees only the sequencer's ports; bound in below its endmodule. */
`timescale 1ns/1ps
`default_nettype none
module acq_seq_monitor (
   input wire clk_i,            // Clock
   input wire rst_i,            // Reset
   input wire stop_key_i,       // Stop key
   input wire capture_done_i,   // Capture done
   input wire arm_o,            // Armed
   input wire busy_o,           // Running
   input wire [1:0] rec_len_o,  // Length code
   input wire [3:0] win_span_o, // Span step
   input wire avg_accum_o,      // Accumulate
   input wire disp_refresh_o    // Refresh
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   len_legal_a: assert property (rec_len_o != 2'h3)
      else $error("record length code out of range");
   span_legal_a: assert property (win_span_o <= 4'hD)
      else $error("window span step out of range");
   len_steady_a: assert property (busy_o && $past(busy_o) |-> $stable(rec_len_o))
      else $error("record length changed mid sequence");
   arm_busy_a: assert property (arm_o |-> busy_o)
      else $error("armed while idle");
   // Recycle counts in the bench are all well above eight cycles
   recycle_gap_a: assert property (arm_o && capture_done_i |=> !arm_o [*8])
      else $error("rearmed too soon");
   stop_key_a: assert property (stop_key_i [*4] |-> ##[0:4] !busy_o)
      else $error("stop key ignored");
   refresh_one_a: assert property (disp_refresh_o |-> busy_o ##1 !disp_refresh_o)
      else $error("refresh pulse malformed");
   accum_one_a: assert property (avg_accum_o |=> !avg_accum_o)
      else $error("accumulate pulse too long");
endmodule

bind acq_record_sequencer acq_seq_monitor u_mon (
   .clk_i(clk_i), .rst_i(rst_i), .stop_key_i(stop_key_i),
   .capture_done_i(capture_done_i), .arm_o(arm_o), .busy_o(busy_o),
   .rec_len_o(rec_len_o), .win_span_o(win_span_o),
   .avg_accum_o(avg_accum_o), .disp_refresh_o(disp_refresh_o));
`default_nettype wire

/* File: verification/capture_engine_model.sv */
/* Capture engine stand-in: answers each arming with one done pulse while trig_en_i is high.
   Assumes arm_i is a registered level on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module capture_engine_model (
   input wire logic clk_i,      // Clock
   input wire logic rst_i,      // Reset
   input wire logic arm_i,      // Engine armed
   input wire logic [7:0] dly_i, // Capture time in cycles
   input wire logic trig_en_i,  // Triggers present
   output logic trig_o,         // Trigger pin
   output logic done_o          // Capture finished pulse
);
   int cnt;
   assign trig_o = trig_en_i;
   always @(posedge clk_i) begin
      if (rst_i || !arm_i || done_o) begin
         cnt <= 0;
         done_o <= 1'b0;
      end else if (cnt >= int'(dly_i)) begin
         // No trigger, no capture: the sequencer must time out on its own
         if (trig_en_i)
            done_o <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/* Self-checking bench for acq_record_sequencer.
   Classic Wishbone master and a capture engine model; counts shortened. */
`timescale 1ns/1ps
`default_nettype none
`include "acq_seq_consts.vh"
module tb;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, stop_key_i, readout_req_i, trig_en, pa;
   logic [7:0] adr_i, dly;
   logic [31:0] dat_i, dat_o, q;
   logic [3:0] sel_i, slot_o, win_span_o;
   logic [1:0] rec_len_o;
   logic ack_o, trig_i, capture_done_i, arm_o, avg_clear_o, avg_accum_o;
   logic disp_refresh_o, readout_grant_o, busy_o;
   int err_count, comparisons, nacc, nclr, nref, ncd, k, n, g, kd;
   logic [31:0] cfg_t[5] = '{32'h5504, 32'h3E15, 32'hF025, 32'h121D, 32'h1705};
   int ncap_t[5] = '{1, 4, 16, 2, 2};
   int gap_t[5] = '{0, 30, 40, 25, 20};

   acq_record_sequencer #(.RECYCLE_256_CYC(20), .RECYCLE_512_CYC(30),
      .RECYCLE_1024_CYC(40), .FAST_512_CYC(25), .REFRESH_CYC(50),
      .TRIG_TIMEOUT_CYC(60)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
      .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .trig_i(trig_i),
      .stop_key_i(stop_key_i), .readout_req_i(readout_req_i),
      .capture_done_i(capture_done_i), .arm_o(arm_o), .slot_o(slot_o),
      .rec_len_o(rec_len_o), .win_span_o(win_span_o), .avg_clear_o(avg_clear_o),
      .avg_accum_o(avg_accum_o), .disp_refresh_o(disp_refresh_o),
      .readout_grant_o(readout_grant_o), .busy_o(busy_o));
   capture_engine_model u_eng (.clk_i(clk_i), .rst_i(rst_i), .arm_i(arm_o),
      .dly_i(dly), .trig_en_i(trig_en), .trig_o(trig_i), .done_o(capture_done_i));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (avg_clear_o === 1'b1) nclr <= nclr + 1;
      if (avg_clear_o === 1'b1) nacc <= 0;
      else if (avg_accum_o === 1'b1) nacc <= nacc + 1;
      if (disp_refresh_o === 1'b1) nref <= nref + 1;
      if (capture_done_i === 1'b1) ncd <= ncd + 1;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One classic cycle; the caller's next request waits for a fresh edge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= (a == `OFS_CTRL) ? 4'h1 : 4'hF;
      adr_i <= a;
      dat_i <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack_o !== 1'b1 && i < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (i == 20) begin
         err_count++;
         tally_and_finish();
      end
   endtask

   task wait_busy(input logic v);
      int i;
      i = 0;
      while (busy_o !== v && i < 400) begin
         @(posedge clk_i);
         i++;
      end
      chk(busy_o, v);
      if (i == 400) tally_and_finish();
   endtask

   initial begin
      {cyc_i, stb_i, we_i, stop_key_i, readout_req_i} = 5'h00;
      adr_i = 8'h00;
      dat_i = 32'h0;
      sel_i = 4'hF;
      trig_en = 1'b1;
      dly = 8'h02;
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(rec_len_o, `LEN_512);
      chk(win_span_o, `RST_WIN);
      wb(1'b0, `OFS_CFG, 32'h0);
      chk(q, 32'h10);
      wb(1'b0, 8'h14, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, `OFS_WIN, 32'hF);
      wb(1'b0, `OFS_WIN, 32'h0);
      chk(q, 32'hD);
      for (int r = 0; r < 5; r++) begin
         wb(1'b1, `OFS_CFG, cfg_t[r]);
         wb(1'b1, `OFS_CTRL, 32'h1);
         wait_busy(1'b1);
         chk(rec_len_o, cfg_t[r][5:4]);
         n = 0;
         g = 0;
         k = 0;
         kd = 0;
         pa = 1'b1;
         while (busy_o === 1'b1 && k < 3000) begin
            @(posedge clk_i);
            k++;
            if (capture_done_i === 1'b1) begin
               chk(slot_o, (cfg_t[r][1:0] == `MODE_ADVANCE) ? (cfg_t[r][11:8] + n) & 32'hF
                  : cfg_t[r][11:8]);
               n++;
               kd = k;
            end
            if (n == 1 && arm_o === 1'b1 && pa !== 1'b1) g = k - kd;
            pa = arm_o;
         end
         if (k == 3000) err_count++;
         chk(n, ncap_t[r]);
         if (gap_t[r] != 0) chk(g >= gap_t[r] - 5 && g <= gap_t[r] + 3, 1);
      end
      wb(1'b0, `OFS_CFG, 32'h0);
      chk(q, cfg_t[4]);
      wb(1'b1, `OFS_CFG, 32'h0);
      wb(1'b1, `OFS_CTRL, 32'h1);
      wait_busy(1'b1);
      k = ncd;
      n = 0;
      while (ncd < k + 2 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk(busy_o, 1'b1);
      wb(1'b1, `OFS_CTRL, 32'h2);
      wait_busy(1'b0);
      wb(1'b1, `OFS_CTRL, 32'h1);
      wait_busy(1'b1);
      stop_key_i <= 1'b1;
      wait_busy(1'b0);
      stop_key_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b1, `OFS_CTRL, 32'h1);
      wait_busy(1'b1);
      trig_en <= 1'b0;
      wait_busy(1'b0);
      trig_en <= 1'b1;
      dly <= 8'h14;
      wb(1'b1, `OFS_CNT, 32'h3);
      wb(1'b1, `OFS_CFG, 32'h16);
      readout_req_i <= 1'b1;
      wb(1'b1, `OFS_CTRL, 32'h1);
      n = 0;
      while (nacc != 1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk(readout_grant_o, 1'b0);
      k = nclr;
      wb(1'b1, `OFS_WIN, 32'h3);
      n = 0;
      while (nclr == k && n < 10) begin
         @(posedge clk_i);
         n++;
      end
      chk(nclr > k, 1);
      chk(win_span_o, 4'hD);
      wb(1'b0, `OFS_WIN, 32'h0);
      chk(q, 32'h3);
      n = 0;
      while (readout_grant_o !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 2000) err_count++;
      chk(nacc, 3);
      chk(nref > 0, 1);
      wb(1'b1, `OFS_CTRL, 32'h2);
      wait_busy(1'b0);
      readout_req_i <= 1'b0;
      wb(1'b1, `OFS_CTRL, 32'h1);
      wait_busy(1'b1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(busy_o, 1'b0);
      chk(rec_len_o, `LEN_512);
      tally_and_finish();
   end
endmodule
`default_nettype wire
